// [verilog/status_led_cfg.svh]
// Overview of operation
// - Patterns repeat every one second by default
// - Init, halt and running patterns as listed
// - Fault codes two to five patterns
// - Shutdown cycles four colours over eight seconds
// - Power-fail-disabled pattern over two seconds
// - Network state codes nine to C patterns
// - Identify shows power source; debugging red blink
// - Shutdown and power-fail indications latch until unpowered
// - Power indicator red whenever powered
// - Word order selects which half goes first
// - Panel partner needs high-word-first on both sides
// - Fixed-point and integer values held 32-bit signed
// - Fixed-point carried as 16.16 with floats
`ifndef STATUS_LED_CFG_SVH
`define STATUS_LED_CFG_SVH

`define CLK_FREQ_HZ 100000000
`define BASE_PERIOD_MS 1000
// Slot count: each pattern period is split into 20 slots of 5 %
`define SLOTS_PER_PERIOD 20
`define SLOT_BASE_CYCLES ((`CLK_FREQ_HZ / 1000) * `BASE_PERIOD_MS / `SLOTS_PER_PERIOD)
`define SHUTDOWN_PERIOD_S 8
`define PFAIL_PERIOD_S 2

`define CODE_INIT 4'h0
`define CODE_HALT 4'h1
`define CODE_NOCFG 4'h2
`define CODE_LERR 4'h3
`define CODE_HERR 4'h4
`define CODE_STFAIL 4'h5
`define CODE_SHUTDOWN 4'h6
`define CODE_OK 4'h7
`define CODE_PFAIL 4'h8
`define CODE_NETFAIL 4'h9
`define CODE_NETCHECK 4'hA
`define CODE_PEERHALT 4'hB
`define CODE_DUPADDR 4'hC

`define FRAC_BITS 16
`define WORD_BITS 32
`define HALF_BITS 16

`endif

// [verilog/status_led_pkg.sv]
package status_led_pkg;

    // Colour on the two-element lamp
    typedef enum logic [1:0] {
        COL_OFF = 2'h0,
        COL_GREEN = 2'h1,
        COL_RED = 2'h2,
        COL_ORANGE = 2'h3
    } colour_e;

    // Source of the indication shown on the lamp
    typedef enum logic [3:0] {
        SRC_STATE = 4'h1,
        SRC_DEBUG = 4'h2,
        SRC_IDENT = 4'h4,
        SRC_HWINIT = 4'h8
    } source_e;

    // Power source reported on identify
    typedef enum logic [1:0] {
        PWR_USB = 2'h0,
        PWR_DRIVE = 2'h1,
        PWR_EXTERNAL = 2'h2
    } power_src_e;

    // Word order on the slave link
    typedef enum logic {
        ORDER_LOW_FIRST = 1'b0,
        ORDER_HIGH_FIRST = 1'b1
    } word_order_e;

    typedef logic signed [31:0] fixed_t;
    typedef logic signed [31:0] int32_t;

endpackage

// [verilog/slot_timer.sv]
`timescale 1ns/100ps
`include "status_led_cfg.svh"

// Divides the clock into pattern slots and counts slots within a period
module slot_timer #(
    parameter int SLOT_CYCLES = `SLOT_BASE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic [3:0] scale,
    output logic [4:0] slot_q
);
    logic [31:0] cyc_q;
    logic [31:0] limit;

    // Scaled slot length for long periods
    assign limit = SLOT_CYCLES * scale;

    // Cycle counter restarts with the pattern
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cyc_q <= 32'h0;
        else if (restart || cyc_q >= limit - 32'h1)
            cyc_q <= 32'h0;
        else
            cyc_q <= cyc_q + 32'h1;
    end

    // Slot index wraps at the end of the period
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            slot_q <= 5'h0;
        else if (restart)
            slot_q <= 5'h0;
        else if (cyc_q >= limit - 32'h1)
            slot_q <= (slot_q == 5'(`SLOTS_PER_PERIOD - 1)) ? 5'h0 : slot_q + 5'h1;
    end
endmodule

// [verilog/word_packer.sv]
`timescale 1ns/100ps
`include "status_led_cfg.svh"

// Splits a 32-bit value into two link registers and joins them back
module word_packer (
    input wire logic sys_clk,
    input wire logic rst_n,
    input status_led_pkg::word_order_e order,
    input wire logic [31:0] tx_value,
    input wire logic [15:0] rx_reg_lo,
    input wire logic [15:0] rx_reg_hi,
    output logic [15:0] tx_reg_lo_q,
    output logic [15:0] tx_reg_hi_q,
    output logic [31:0] rx_value_q
);
    import status_led_pkg::*;

    // Lower register number holds the half chosen by the order
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_reg_lo_q <= 16'h0;
            tx_reg_hi_q <= 16'h0;
        end
        else if (order == ORDER_HIGH_FIRST)
        begin
            tx_reg_lo_q <= tx_value[31:16];
            tx_reg_hi_q <= tx_value[15:0];
        end
        else
        begin
            tx_reg_lo_q <= tx_value[15:0];
            tx_reg_hi_q <= tx_value[31:16];
        end
    end

    // Reassembly of a received pair
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rx_value_q <= 32'h0;
        else if (order == ORDER_HIGH_FIRST)
            rx_value_q <= {rx_reg_lo, rx_reg_hi};
        else
            rx_value_q <= {rx_reg_hi, rx_reg_lo};
    end
endmodule

// [verilog/module_status_led_sequencer.sv]
`timescale 1ns/100ps
`include "status_led_cfg.svh"

// Module status lamp, power lamp and link word-ordering helper
module module_status_led_sequencer #(
    parameter int SLOT_CYCLES = `SLOT_BASE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] network_controller_state_code,
    input wire logic debug_mode,
    input wire logic identify_req,
    input wire logic hw_init,
    input status_led_pkg::power_src_e power_src,
    input status_led_pkg::word_order_e word_order,
    input wire logic [31:0] tx_value,
    input wire logic [15:0] rx_reg_lo,
    input wire logic [15:0] rx_reg_hi,
    input wire logic [31:0] float_in,
    output logic status_red_q,
    output logic status_green_q,
    output logic power_red_q,
    output logic latched_q,
    output logic [15:0] tx_reg_lo_q,
    output logic [15:0] tx_reg_hi_q,
    output logic [31:0] rx_value_q,
    output logic [31:0] fixed_from_float_q
);
    import status_led_pkg::*;

    logic [2:0] pin_sync_q;
    logic [2:0] pin_mid_q;
    logic [2:0] pin_last_q;
    logic [2:0] ovr_q;
    logic [1:0] pwr_sync_q;
    logic [1:0] pwr_mid_q;
    logic [1:0] pwr_last_q;
    logic [1:0] pwr_q;
    logic [3:0] code_q;
    logic [3:0] latch_code_q;
    logic [3:0] eff_code;
    logic [3:0] prev_code_q;
    source_e src_d;
    source_e src_q;
    logic restart;
    logic [3:0] scale;
    logic [4:0] slot_raw;
    logic [4:0] slot;
    colour_e colour;

    // State code from the module controller, same clock, registered once
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            code_q <= `CODE_INIT;
        else
            code_q <= network_controller_state_code;
    end

    // Tool and supply-sense levels cross into this clock through three stages
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_sync_q <= 3'h0;
            pin_mid_q <= 3'h0;
            pin_last_q <= 3'h0;
            pwr_sync_q <= 2'h0;
            pwr_mid_q <= 2'h0;
            pwr_last_q <= 2'h0;
        end
        else
        begin
            pin_sync_q <= {hw_init, identify_req, debug_mode};
            pin_mid_q <= pin_sync_q;
            pin_last_q <= pin_mid_q;
            pwr_sync_q <= power_src;
            pwr_mid_q <= pwr_sync_q;
            pwr_last_q <= pwr_mid_q;
        end
    end

    // A level counts once the last two stages agree, so one-cycle blips are dropped
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ovr_q <= 3'h0;
            pwr_q <= 2'h0;
        end
        else
        begin
            ovr_q <= (pin_mid_q & pin_last_q) | (ovr_q & (pin_mid_q | pin_last_q));
            pwr_q <= (pwr_mid_q & pwr_last_q) | (pwr_q & (pwr_mid_q | pwr_last_q));
        end
    end

    // Shutdown and power-fail codes latch until power goes away
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            latch_code_q <= 4'h0;
        else if (latch_code_q == 4'h0 &&
                 (code_q == `CODE_SHUTDOWN || code_q == `CODE_PFAIL))
            latch_code_q <= code_q;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            latched_q <= 1'b0;
        else
            latched_q <= (latch_code_q != 4'h0);
    end

    assign eff_code = (latch_code_q != 4'h0) ? latch_code_q : code_q;

    // Indication source priority: latched code, hardware init, identify, debug, state
    always_comb
    begin
        if (latch_code_q != 4'h0)
            src_d = SRC_STATE;
        else if (ovr_q[2])
            src_d = SRC_HWINIT;
        else if (ovr_q[1])
            src_d = SRC_IDENT;
        else if (ovr_q[0])
            src_d = SRC_DEBUG;
        else
            src_d = SRC_STATE;
    end

    // Source shown last cycle, for change detection
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            src_q <= SRC_STATE;
        else
            src_q <= src_d;
    end

    // Code shown last cycle, for change detection
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_code_q <= `CODE_INIT;
        else
            prev_code_q <= eff_code;
    end

    // A change of source or of effective code restarts the pattern
    assign restart = (src_d != src_q) || (eff_code != prev_code_q);

    // A restart shows slot 0 at once rather than one stale slot
    assign slot = restart ? 5'h0 : slot_raw;

    // Period stretch for the long patterns
    always_comb
    begin
        if (src_d == SRC_STATE && eff_code == `CODE_SHUTDOWN)
            scale = 4'(`SHUTDOWN_PERIOD_S);
        else if (src_d == SRC_STATE && eff_code == `CODE_PFAIL)
            scale = 4'(`PFAIL_PERIOD_S);
        else
            scale = 4'h1;
    end

    slot_timer #(
        .SLOT_CYCLES(SLOT_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .restart(restart),
        .scale(scale),
        .slot_q(slot_raw)
    );

    // Colour for the current 5 % slot
    always_comb
    begin
        colour = COL_OFF;
        case (src_d)
            SRC_HWINIT:
                if (slot < 5'd5)
                    colour = COL_ORANGE;
                else if (slot < 5'd10)
                    colour = COL_RED;
                else if (slot < 5'd15)
                    colour = COL_ORANGE;
                else
                    colour = COL_GREEN;
            SRC_IDENT:
                case (power_src_e'(pwr_q))
                    PWR_USB: colour = (slot < 5'd5) ? COL_ORANGE : COL_OFF;
                    PWR_DRIVE: colour = (slot < 5'd10) ? COL_ORANGE : COL_OFF;
                    default: colour = (slot < 5'd15) ? COL_ORANGE : COL_OFF;
                endcase
            SRC_DEBUG:
                colour = (slot < 5'd5) ? COL_RED : COL_OFF;
            SRC_STATE:
                case (eff_code)
                    `CODE_INIT: colour = (slot < 5'd2) ? COL_GREEN : COL_OFF;
                    `CODE_HALT: colour = (slot < 5'd19) ? COL_RED : COL_GREEN;
                    `CODE_NOCFG: colour = (slot < 5'd10) ? COL_RED : COL_OFF;
                    `CODE_LERR: colour = (slot < 5'd10) ? COL_GREEN : COL_RED;
                    `CODE_HERR: colour = (slot < 5'd10) ? COL_ORANGE : COL_RED;
                    `CODE_STFAIL: colour = (slot < 5'd10) ? COL_GREEN : COL_ORANGE;
                    `CODE_SHUTDOWN: colour = (slot < 5'd6) ? COL_GREEN :
                        (slot < 5'd12) ? COL_ORANGE : (slot < 5'd18) ? COL_RED : COL_OFF;
                    `CODE_OK: colour = (slot < 5'd19) ? COL_GREEN : COL_OFF;
                    `CODE_PFAIL: colour = (slot < 5'd5) ? COL_ORANGE :
                        (slot < 5'd15) ? COL_GREEN : COL_OFF;
                    `CODE_NETFAIL: colour = (slot < 5'd10) ? COL_GREEN : COL_OFF;
                    `CODE_NETCHECK: colour = (slot < 5'd5) ? COL_GREEN : COL_OFF;
                    `CODE_PEERHALT: colour = (slot < 5'd10) ? COL_RED :
                        (slot < 5'd17) ? COL_GREEN : COL_OFF;
                    `CODE_DUPADDR: colour = (slot < 5'd15) ? COL_GREEN : COL_RED;
                    default: colour = COL_OFF;
                endcase
            default: colour = COL_OFF;
        endcase
    end

    // Lamp drive; orange lights both elements
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_red_q <= 1'b0;
            status_green_q <= 1'b0;
        end
        else
        begin
            status_red_q <= colour[1];
            status_green_q <= colour[0];
        end
    end

    // Power lamp lit from the first edge after reset
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            power_red_q <= 1'b0;
        else
            power_red_q <= 1'b1;
    end

    // Word order from the port; a panel partner needs high-word-first
    word_packer u_pack (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .order(word_order),
        .tx_value(tx_value),
        .rx_reg_lo(rx_reg_lo),
        .rx_reg_hi(rx_reg_hi),
        .tx_reg_lo_q(tx_reg_lo_q),
        .tx_reg_hi_q(tx_reg_hi_q),
        .rx_value_q(rx_value_q)
    );

    // IEEE single to 16.16 fixed point, saturating at the range ends
    function automatic fixed_t float_to_fixed(input logic [31:0] f);
        logic [7:0] e;
        logic [62:0] mag;
        logic [31:0] res;
        e = f[30:23];
        mag = 63'h0;
        res = 32'h0;
        if (e >= 8'd142)
            res = f[31] ? 32'h80000000 : 32'h7FFFFFFF;
        else if (e >= 8'd103)
        begin
            mag = {39'h0, 1'b1, f[22:0]} << (e - 8'd103);
            res = f[31] ? (32'h0 - mag[62:31]) : mag[62:31];
        end
        return fixed_t'(res);
    endfunction

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            fixed_from_float_q <= 32'h0;
        else
            fixed_from_float_q <= float_to_fixed(float_in);
    end
endmodule

// [sim/status_led_checker_assertions.sv]
`timescale 1ns/100ps
// Port-level checks on the status and power lamps
module status_led_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] network_controller_state_code,
    input wire logic debug_mode,
    input wire logic identify_req,
    input wire logic hw_init,
    input wire logic status_red_q,
    input wire logic status_green_q,
    input wire logic power_red_q,
    input wire logic latched_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // State code with a flag telling that no override is active
    wire logic [4:0] sc = {!latched_q && !hw_init && !identify_req && !debug_mode,
        network_controller_state_code};
    AST_POWER_LAMP: assert property ($past(rst_n) |-> power_red_q)
        else $error("power lamp dark while powered");
    AST_LATCH_HOLD: assert property (latched_q |=> latched_q)
        else $error("latched indication cleared");
    AST_LATCH_SET: assert property (network_controller_state_code inside {4'h6, 4'h8}
        |-> ##[1:4] latched_q)
        else $error("shutdown code not latched");
    AST_NO_RED: assert property ((sc inside {5'h10, 5'h17, 5'h19, 5'h1A})[*6] |-> !status_red_q)
        else $error("red lit on a green-only code");
    AST_NOCFG: assert property ((sc == 5'h12)[*6] |-> !status_green_q)
        else $error("green lit on the no-setup code");
    AST_NO_ORANGE: assert property ((sc inside {5'h13, 5'h1C})[*6] |-> !(status_red_q && status_green_q))
        else $error("orange on a two-colour code");
    AST_HERR_RED: assert property ((sc == 5'h14)[*6] |-> status_red_q)
        else $error("red dark on the high-level error code");
    AST_STFAIL_GREEN: assert property ((sc == 5'h15)[*6] |-> status_green_q)
        else $error("green dark on the self-test code");
    AST_IDENT: assert property ((identify_req && !hw_init && !latched_q)[*6]
        |-> status_red_q == status_green_q)
        else $error("identify shows a single colour");
    AST_DEBUG: assert property ((debug_mode && !identify_req && !hw_init && !latched_q)[*6]
        |-> !status_green_q)
        else $error("green lit while debugging");
endmodule

bind module_status_led_sequencer status_led_checker chk (
    .sys_clk, .rst_n, .network_controller_state_code, .debug_mode, .identify_req, .hw_init,
    .status_red_q, .status_green_q, .power_red_q, .latched_q
);

// [sim/panel_model.sv]
`timescale 1ns/100ps
// Operator panel: writes 32-bit values as register pairs
module panel_model (
    input wire logic low_first,
    input wire logic [31:0] wr_value,
    output status_led_pkg::word_order_e word_order,
    output logic [15:0] rx_reg_lo,
    output logic [15:0] rx_reg_hi
);
    import status_led_pkg::*;
    localparam int MAX_SEGMENT = 232;
    localparam int PING_REG = 511;
    // Remote I/O polling interval the panel keeps to, in milliseconds
    localparam int MIN_ACCESS_MS = 5;
    // Both ends share one order; high word first unless a test asks otherwise
    assign word_order = low_first ? ORDER_LOW_FIRST : ORDER_HIGH_FIRST;
    assign rx_reg_lo = low_first ? wr_value[15:0] : wr_value[31:16];
    assign rx_reg_hi = low_first ? wr_value[31:16] : wr_value[15:0];
endmodule

// [sim/tb.sv]
`timescale 1ns/100ps
// Lamp pattern table, then latch, reset and word handling
module tb;
    import status_led_pkg::*;
    typedef struct {logic [3:0] c; logic [2:0] ov; logic [1:0] ps; int sc; string pat;} row_s;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] code = 4'h0;
    logic dbg = 1'b0;
    logic idn = 1'b0;
    logic hwi = 1'b0;
    logic [1:0] src = 2'h0;
    logic low_first = 1'b0;
    logic [31:0] tx_value = 32'h0;
    logic [31:0] wr_value = 32'h0;
    logic [31:0] float_in = 32'h0;
    word_order_e wo;
    logic [15:0] rlo, rhi, tlo, thi;
    logic [31:0] rxv, fxq;
    logic red, grn, pwr, lat;
    int miscompares = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0 = 0;
    // Inputs beside the expected colour of each of the 20 slots
    row_s rows [20] = '{'{4'h0, 3'h0, 2'h0, 1, "GG------------------"},
        '{4'h1, 3'h0, 2'h0, 1, "RRRRRRRRRRRRRRRRRRRG"}, '{4'h2, 3'h0, 2'h0, 1, "RRRRRRRRRR----------"},
        '{4'h3, 3'h0, 2'h0, 1, "GGGGGGGGGGRRRRRRRRRR"}, '{4'h4, 3'h0, 2'h0, 1, "OOOOOOOOOORRRRRRRRRR"},
        '{4'h5, 3'h0, 2'h0, 1, "GGGGGGGGGGOOOOOOOOOO"}, '{4'h7, 3'h0, 2'h0, 1, "GGGGGGGGGGGGGGGGGGG-"},
        '{4'h9, 3'h0, 2'h0, 1, "GGGGGGGGGG----------"}, '{4'hA, 3'h0, 2'h0, 1, "GGGGG---------------"},
        '{4'hB, 3'h0, 2'h0, 1, "RRRRRRRRRRGGGGGGG---"}, '{4'hC, 3'h0, 2'h0, 1, "GGGGGGGGGGGGGGGRRRRR"},
        '{4'h7, 3'h1, 2'h0, 1, "RRRRR---------------"}, '{4'h7, 3'h2, 2'h0, 1, "OOOOO---------------"},
        '{4'h7, 3'h2, 2'h1, 1, "OOOOOOOOOO----------"}, '{4'h7, 3'h3, 2'h2, 1, "OOOOOOOOOOOOOOO-----"},
        '{4'h7, 3'h4, 2'h0, 1, "OOOOORRRRROOOOOGGGGG"}, '{4'h2, 3'h6, 2'h2, 1, "OOOOORRRRROOOOOGGGGG"},
        '{4'hD, 3'h0, 2'h0, 1, "--------------------"}, '{4'h8, 3'h0, 2'h0, 2, "OOOOOGGGGGGGGGG-----"},
        '{4'h6, 3'h0, 2'h0, 8, "GGGGGGOOOOOORRRRRR--"}};

    module_status_led_sequencer #(.SLOT_CYCLES(10)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .network_controller_state_code(code),
        .debug_mode(dbg), .identify_req(idn), .hw_init(hwi), .power_src(power_src_e'(src)),
        .word_order(wo), .tx_value(tx_value), .rx_reg_lo(rlo), .rx_reg_hi(rhi),
        .float_in(float_in), .status_red_q(red), .status_green_q(grn), .power_red_q(pwr),
        .latched_q(lat), .tx_reg_lo_q(tlo), .tx_reg_hi_q(thi), .rx_value_q(rxv),
        .fixed_from_float_q(fxq));
    panel_model panel (.low_first(low_first), .wr_value(wr_value), .word_order(wo),
        .rx_reg_lo(rlo), .rx_reg_hi(rhi));

    always #5 sys_clk = ~sys_clk;
    // Edge counter for slot timing
    always @(posedge sys_clk) cyc <= cyc + 1;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Samples the lamp mid-slot, slots counted from the input change at t0
    task automatic slots(input string pat, input int sc, input int first, input int last);
        logic [1:0] e;
        for (int k = first; k <= last; k++)
        begin
            while (cyc < t0 + 3 + 10 * sc * k + 5 * sc) @(negedge sys_clk);
            e = pat[k % 20] == "G" ? 2'h1 : pat[k % 20] == "R" ? 2'h2 :
                pat[k % 20] == "O" ? 2'h3 : 2'h0;
            chk({30'h0, red, grn}, {30'h0, e});
        end
    endtask

    task automatic do_reset;
        rst_n = 1'b0;
        {code, dbg, idn, hwi} = 7'h0;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(negedge sys_clk);
        chk({28'h0, red, grn, pwr, lat}, 32'h0);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({31'h0, pwr}, 32'h1);
        foreach (rows[i])
        begin
            do_reset();
            {code, hwi, idn, dbg, src} = {rows[i].c, rows[i].ov, rows[i].ps};
            t0 = cyc;
            slots(rows[i].pat, rows[i].sc, 0, 19);
        end
        // Latched shutdown ignores a new code and a debug request
        {code, dbg} = {4'h2, 1'b1};
        slots(rows[19].pat, 8, 20, 39);
        chk({31'h0, lat}, 32'h1);
        do_reset();
        chk({31'h0, lat}, 32'h0);
        // Word order in both directions, both settings
        for (int o = 0; o < 2; o++)
        begin
            low_first = o[0];
            tx_value = 32'h9ABC_DEF0;
            wr_value = 32'h1234_5678;
            repeat (4) @(negedge sys_clk);
            chk({thi, tlo}, o ? 32'h9ABC_DEF0 : 32'hDEF0_9ABC);
            chk(rxv, 32'h1234_5678);
        end
        float_in = 32'h3FC0_0000;
        repeat (4) @(negedge sys_clk);
        chk(fxq, 32'h0001_8000);
        float_in = 32'hC000_0000;
        repeat (4) @(negedge sys_clk);
        chk(fxq, 32'hFFFE_0000);
        float_in = 32'h4800_0000;
        repeat (4) @(negedge sys_clk);
        chk(fxq, 32'h7FFF_FFFF);
        wrap_up();
    end

    // Cuts a hang short
    initial
    begin
        repeat (30000) @(posedge sys_clk);
        miscompares++;
        wrap_up();
    end
endmodule
